// ---- verilog/gas_gauge_threshold_counter.sv ----
`timescale 1ns/1ps
module gas_gauge_threshold_counter
  import gauge_pkg::*;
#(
  parameter int RESUME_COUNT = RESUME_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [MV_W-1:0] CELL_MV_I,
  input wire logic HEAVY_DISCHARGE_I,
  input wire logic THRESH_WR_I,
  input wire logic [MV_W-1:0] EARLY_LEVEL_I,
  input wire logic [MV_W-1:0] EMPTY_LEVEL_I,
  input wire logic RESET_CMD_I,
  input wire logic signed [7:0] TEMP_C_I,
  input wire logic FAST_RATE_I,
  input wire logic CHARGE_EVENT_I,
  input wire logic DISCHARGE_EVENT_I,
  input wire logic SELF_DISCHARGE_EVENT_I,
  input wire logic [1:0] PROG1_I,
  input wire logic [1:0] PROG2_I,
  input wire logic [1:0] PROG3_I,
  input wire logic [1:0] PROG4_I,
  output logic [MV_W-1:0] CELL_MV_O,
  output logic [7:0] TEMP_CODE_O,
  output logic [7:0] CHARGE_COUNT_LOW_O,
  output logic [7:0] CHARGE_COUNT_HIGH_O,
  output logic [15:0] DISCHARGE_COUNT_O,
  output logic [15:0] LEARNED_CAPACITY_O,
  output logic [15:0] PROGRAMMED_FULL_CAPACITY_O,
  output logic EARLY_FLAG_O,
  output logic EMPTY_FLAG_O,
  output logic EMPTY_O,
  output logic EMPTY_OE_O,
  output logic FAULT_O,
  output logic BATT_PRESENT_O,
  output logic VALID_CHARGE_O,
  output logic [DISPLAY_BARS-1:0] DISPLAY_BARS_O
);

  generate
    if (RESUME_COUNT < 1) begin : g_bad_resume
      $error("RESUME_COUNT must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // level index: high 0, float 1, low 2; an illegal code counts as high
  function automatic logic [1:0] lvl_index(input logic [1:0] code);
    unique case (code)
      LVL_LOW: lvl_index = 2'h2;
      LVL_FLOAT: lvl_index = 2'h1;
      default: lvl_index = 2'h0;
    endcase
  endfunction

  function automatic logic [3:0] temp_step(input logic signed [7:0] t);
    int v;
    v = int'(t);
    if (v < TEMP_FLOOR_C) begin
      temp_step = 4'h0;
    end else if (((v + TEMP_OFFSET_C) / TEMP_STEP_C) >= int'(TEMP_CODE_MAX)) begin
      temp_step = TEMP_CODE_MAX;
    end else begin
      temp_step = 4'((v + TEMP_OFFSET_C) / TEMP_STEP_C);
    end
  endfunction

  // ----------------------------------------------------------------
  // reset triggers and sampled voltage
  // ----------------------------------------------------------------
  logic [MV_W-1:0] cell_prev_reg, cell_prev_next;
  logic trig_reg, trig_next;
  logic rst;

  always_comb begin
    cell_prev_next = CELL_MV_I;
    trig_next = ((cell_prev_reg < RESTART_LOW_MV) && (CELL_MV_I >= RESTART_LOW_MV))
      || ((cell_prev_reg > MAX_CELL_MV) && (CELL_MV_I <= MAX_CELL_MV))
      || RESET_CMD_I;
  end

  // the previous sample sees only the pin reset, so a restart cannot retrigger itself
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      cell_prev_reg <= '0;
      trig_reg <= 1'b0;
    end else begin
      cell_prev_reg <= cell_prev_next;
      trig_reg <= trig_next;
    end
  end

  assign rst = SRST_I | trig_reg;

  // ----------------------------------------------------------------
  // temperature and compensation
  // ----------------------------------------------------------------
  logic [3:0] tcode;
  logic [WEIGHT_W-1:0] w_chg, w_dsg, w_self;
  logic tick_chg, tick_dsg, tick_self;

  // rate only affects charge and discharge
  always_comb begin
    tcode = temp_step(TEMP_C_I);
    w_chg = (tcode <= TEMP_COLD_CODE) ? WEIGHT_COLD_CHG : WEIGHT_FULL;
    if (FAST_RATE_I) begin
      w_chg = w_chg - WEIGHT_FAST_CUT;
    end
    w_dsg = (tcode <= TEMP_COLD_CODE) ? WEIGHT_COLD_DSG : WEIGHT_FULL;
    if (FAST_RATE_I) begin
      w_dsg = w_dsg - WEIGHT_FAST_CUT;
    end
    if (tcode >= TEMP_HOT_CODE) begin
      w_self = WEIGHT_FULL;
    end else if (tcode >= TEMP_WARM_CODE) begin
      w_self = WEIGHT_SELF_MID;
    end else begin
      w_self = WEIGHT_SELF_LOW;
    end
  end

  count_scaler u_chg (
    .clk_i(MCLK_I),
    .rst_i(rst),
    .event_i(CHARGE_EVENT_I),
    .weight_i(w_chg),
    .tick_o(tick_chg)
  );

  count_scaler u_dsg (
    .clk_i(MCLK_I),
    .rst_i(rst),
    .event_i(DISCHARGE_EVENT_I),
    .weight_i(w_dsg),
    .tick_o(tick_dsg)
  );

  count_scaler u_self (
    .clk_i(MCLK_I),
    .rst_i(rst),
    .event_i(SELF_DISCHARGE_EVENT_I),
    .weight_i(w_self),
    .tick_o(tick_self)
  );

  // ----------------------------------------------------------------
  // end-of-discharge monitoring gate
  // ----------------------------------------------------------------
  logic monitor_ok;

  resume_timer #(
    .COUNT(RESUME_COUNT)
  ) u_resume (
    .clk_i(MCLK_I),
    .rst_i(rst),
    .hold_i(HEAVY_DISCHARGE_I),
    .ready_o(monitor_ok)
  );

  // ----------------------------------------------------------------
  // gauge state
  // ----------------------------------------------------------------
  logic init_reg, init_next;
  logic [MV_W-1:0] early_lvl_reg, early_lvl_next;
  logic [MV_W-1:0] empty_lvl_reg, empty_lvl_next;
  logic [15:0] nac_reg, nac_next;
  logic [15:0] dcr_reg, dcr_next;
  logic [15:0] lmd_reg, lmd_next;
  logic [15:0] pfc_reg, pfc_next;
  logic [15:0] step_reg, step_next;
  logic up_reg, up_next;
  logic early_reg, early_next;
  logic empty_reg, empty_next;
  logic qual_reg, qual_next;
  logic learned_reg, learned_next;
  logic charging_reg, charging_next;
  logic valid_reg, valid_next;
  logic [16:0] sum;
  logic [15:0] base;
  logic [3:0] idx;
  logic [15:0] dcr_base;
  logic empty_oe_reg;

  always_comb begin
    init_next = 1'b0;
    early_lvl_next = early_lvl_reg;
    empty_lvl_next = empty_lvl_reg;
    nac_next = nac_reg;
    dcr_next = dcr_reg;
    lmd_next = lmd_reg;
    pfc_next = pfc_reg;
    step_next = step_reg;
    up_next = up_reg;
    early_next = early_reg;
    empty_next = empty_reg;
    qual_next = qual_reg;
    learned_next = learned_reg;
    charging_next = charging_reg;
    valid_next = 1'b0;
    base = nac_reg;
    dcr_base = dcr_reg;
    sum = '0;
    idx = '0;
    if (THRESH_WR_I) begin
      early_lvl_next = EARLY_LEVEL_I;
      empty_lvl_next = EMPTY_LEVEL_I;
    end
    if (init_reg) begin
      // program pins pick capacity and step
      idx = 4'(lvl_index(PROG1_I)) * 4'h3 + 4'(lvl_index(PROG2_I));
      pfc_next = PFC_TABLE[idx];
      lmd_next = PFC_TABLE[idx];
      idx = 4'((lvl_index(PROG4_I) == 2'h2) ? 2'h0 : 2'h1) * 4'h3 + 4'(lvl_index(PROG3_I));
      step_next = STEP_BASE << idx;
      nac_next = COUNT_ZERO;
    end else begin
      // a tick at full counts from a cleared register, so it is not lost
      if ((nac_reg == lmd_reg) && (lmd_reg != COUNT_ZERO)) begin
        dcr_base = COUNT_ZERO;
        dcr_next = COUNT_ZERO;
      end
      // flags sampled on the clock edge
      if (monitor_ok && (CELL_MV_I < early_lvl_reg)) begin
        early_next = 1'b1;
      end
      if (monitor_ok && (CELL_MV_I < empty_lvl_reg)) begin
        empty_next = 1'b1;
      end
      // coincident ticks are served charge first; the others are dropped
      if (tick_chg) begin
        charging_next = 1'b1;
        up_next = 1'b1;
        // new climb starts from a clean low byte
        if (!up_reg) begin
          base = {nac_reg[15:8], LOW_BYTE_CLEAR};
        end
        sum = {1'b0, base} + {1'b0, step_reg};
        nac_next = (sum > {1'b0, lmd_reg}) ? lmd_reg : sum[15:0];
        // only a carry into the high byte counts
        if (sum[16:8] != {1'b0, base[15:8]}) begin
          valid_next = 1'b1;
          early_next = 1'b0;
          empty_next = 1'b0;
          qual_next = 1'b0;
          if (early_reg) begin
            nac_next = COUNT_ZERO;
            if (qual_reg) begin
              lmd_next = dcr_reg;
              learned_next = 1'b1;
            end
          end
        end
      end else if (tick_dsg) begin
        charging_next = 1'b0;
        up_next = 1'b0;
        nac_next = (nac_reg < step_reg) ? COUNT_ZERO : nac_reg - step_reg;
        if (!early_reg) begin
          sum = {1'b0, dcr_base} + {1'b0, step_reg};
          dcr_next = sum[16] ? COUNT_MAX : sum[15:0];
        end
      end else if (tick_self) begin
        up_next = 1'b0;
        nac_next = (nac_reg < step_reg) ? COUNT_ZERO : nac_reg - step_reg;
        if (!early_reg && (nac_reg != COUNT_ZERO)) begin
          sum = {1'b0, dcr_base} + {1'b0, step_reg};
          dcr_next = sum[16] ? COUNT_MAX : sum[15:0];
        end
      end
      // full battery opens a new qualified discharge
      if ((nac_reg == lmd_reg) && (lmd_reg != COUNT_ZERO)) begin
        qual_next = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (rst) begin
      init_reg <= 1'b1;
      early_lvl_reg <= EARLY_LEVEL_MV;
      empty_lvl_reg <= EMPTY_LEVEL_MV;
      nac_reg <= COUNT_ZERO;
      dcr_reg <= COUNT_ZERO;
      lmd_reg <= COUNT_ZERO;
      pfc_reg <= COUNT_ZERO;
      step_reg <= STEP_BASE;
      up_reg <= 1'b0;
      early_reg <= 1'b0;
      empty_reg <= 1'b0;
      qual_reg <= 1'b0;
      learned_reg <= 1'b0;
      charging_reg <= 1'b0;
      valid_reg <= 1'b0;
      empty_oe_reg <= 1'b1;
    end else begin
      init_reg <= init_next;
      early_lvl_reg <= early_lvl_next;
      empty_lvl_reg <= empty_lvl_next;
      nac_reg <= nac_next;
      dcr_reg <= dcr_next;
      lmd_reg <= lmd_next;
      pfc_reg <= pfc_next;
      step_reg <= step_next;
      up_reg <= up_next;
      early_reg <= early_next;
      empty_reg <= empty_next;
      qual_reg <= qual_next;
      learned_reg <= learned_next;
      charging_reg <= charging_next;
      valid_reg <= valid_next;
      empty_oe_reg <= ~empty_next;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic [MV_W-1:0] cell_out_reg;
  logic [7:0] temp_out_reg;
  logic fault_reg, present_reg;
  logic [DISPLAY_BARS-1:0] bars_reg, bars_next;

  // bar k lit when five times charge exceeds k times reference
  genvar k;
  generate
    for (k = 0; k < DISPLAY_BARS; k++) begin : g_bar
      always_comb begin
        bars_next[k] = (19'(nac_reg) * 19'(DISPLAY_BARS)) > (19'(lmd_reg) * 19'(k));
      end
    end
  endgenerate

  always_ff @(posedge MCLK_I) begin
    if (rst) begin
      cell_out_reg <= '0;
      temp_out_reg <= '0;
      fault_reg <= 1'b0;
      present_reg <= 1'b0;
      bars_reg <= '0;
    end else begin
      cell_out_reg <= CELL_MV_I;
      temp_out_reg <= {tcode, TEMP_NIBBLE_LOW};
      fault_reg <= charging_reg && (CELL_MV_I > MAX_CELL_MV);
      present_reg <= CELL_MV_I > PRESENT_MV;
      bars_reg <= (nac_reg == COUNT_ZERO) ? '0 : bars_next;
    end
  end

  assign CELL_MV_O = cell_out_reg;
  assign TEMP_CODE_O = temp_out_reg;
  assign CHARGE_COUNT_LOW_O = nac_reg[7:0];
  assign CHARGE_COUNT_HIGH_O = nac_reg[15:8];
  assign DISCHARGE_COUNT_O = dcr_reg;
  assign LEARNED_CAPACITY_O = lmd_reg;
  assign PROGRAMMED_FULL_CAPACITY_O = pfc_reg;
  assign EARLY_FLAG_O = early_reg;
  assign EMPTY_FLAG_O = empty_reg;
  // open drain pulls low until empty, then floats
  assign EMPTY_O = 1'b0;
  assign EMPTY_OE_O = empty_oe_reg;
  assign FAULT_O = fault_reg;
  assign BATT_PRESENT_O = present_reg;
  assign VALID_CHARGE_O = valid_reg;
  assign DISPLAY_BARS_O = bars_reg;

endmodule // gas_gauge_threshold_counter

// ---- verilog/gauge_pkg.sv ----
package gauge_pkg;

  // ----------------------------------------------------------------
  // voltage levels, all in millivolts of per-cell sense voltage
  // ----------------------------------------------------------------
  localparam int MV_W = 12;
  localparam logic [11:0] EARLY_LEVEL_MV = 12'h41A;
  localparam logic [11:0] EMPTY_LEVEL_MV = 12'h3B6;
  localparam logic [11:0] PRESENT_MV = 12'h064;
  localparam logic [11:0] RESTART_LOW_MV = 12'h0FA;
  localparam logic [11:0] MAX_CELL_MV = 12'h8CA;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESUME_DELAY_MS = 500;
  localparam int RESUME_CYCLES = RESUME_DELAY_MS * 1000000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // three-level program pin codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_FLOAT = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // ----------------------------------------------------------------
  // programmed full capacity, rows H-H, H-Z, H-L, Z-H ... L-L
  // ----------------------------------------------------------------
  localparam logic [15:0] PFC_TABLE [9] = '{
    16'hC000, 16'hB000, 16'hA000, 16'h9000, 16'h8400,
    16'h7800, 16'h6C00, 16'h6400, 16'h5800
  };

  // ----------------------------------------------------------------
  // counters and temperature code
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] STEP_BASE = 16'h0002;
  localparam logic [7:0] LOW_BYTE_CLEAR = 8'h00;
  localparam logic [3:0] TEMP_CODE_MAX = 4'hC;
  localparam int TEMP_FLOOR_C = -30;
  localparam int TEMP_OFFSET_C = 40;
  localparam int TEMP_STEP_C = 10;
  localparam logic [3:0] TEMP_NIBBLE_LOW = 4'h0;
  localparam logic [3:0] TEMP_COLD_CODE = 4'h3;
  localparam logic [3:0] TEMP_WARM_CODE = 4'h7;
  localparam logic [3:0] TEMP_HOT_CODE = 4'h9;

  // ----------------------------------------------------------------
  // compensation weights in sixteenths of a count
  // ----------------------------------------------------------------
  localparam int WEIGHT_W = 5;
  localparam logic [4:0] WEIGHT_FULL = 5'h10;
  localparam logic [4:0] WEIGHT_COLD_CHG = 5'h0C;
  localparam logic [4:0] WEIGHT_FAST_CUT = 5'h02;
  localparam logic [4:0] WEIGHT_COLD_DSG = 5'h0E;
  localparam logic [4:0] WEIGHT_SELF_LOW = 5'h04;
  localparam logic [4:0] WEIGHT_SELF_MID = 5'h08;
  localparam int DISPLAY_BARS = 5;

endpackage

// ---- verilog/count_scaler.sv ----
`timescale 1ns/1ps
module count_scaler
  import gauge_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic event_i,
  input wire logic [WEIGHT_W-1:0] weight_i,
  output logic tick_o
);

  logic [WEIGHT_W-1:0] acc_reg, acc_next;
  logic tick_reg, tick_next;
  logic [WEIGHT_W:0] sum;

  // ----------------------------------------------------------------
  // fractional accumulator
  // ----------------------------------------------------------------
  // weights above one full count would lose ticks, so they are capped
  always_comb begin
    acc_next = acc_reg;
    tick_next = 1'b0;
    sum = {1'b0, acc_reg} + {1'b0, (weight_i > WEIGHT_FULL) ? WEIGHT_FULL : weight_i};
    if (event_i) begin
      if (sum >= {1'b0, WEIGHT_FULL}) begin
        tick_next = 1'b1;
        acc_next = WEIGHT_W'(sum - {1'b0, WEIGHT_FULL});
      end else begin
        acc_next = sum[WEIGHT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule // count_scaler

// ---- verilog/resume_timer.sv ----
`timescale 1ns/1ps
module resume_timer
  import gauge_pkg::*;
#(
  parameter int COUNT = RESUME_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hold_i,
  output logic ready_o
);

  localparam int CW = $clog2(COUNT + 1);

  logic [CW-1:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;

  generate
    if (COUNT < 1) begin : g_bad_count
      $error("resume_timer needs COUNT of at least one");
    end
  endgenerate

  // ----------------------------------------------------------------
  // hold-off counter
  // ----------------------------------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    ready_next = ready_reg;
    if (hold_i) begin
      cnt_next = '0;
      ready_next = 1'b0;
    end else if (!ready_reg) begin
      if (cnt_reg == CW'(COUNT - 1)) begin
        ready_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      ready_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  assign ready_o = ready_reg;

endmodule // resume_timer

// ---- bench/gauge_chk.sv ----
`timescale 1ns/1ps
module gauge_chk
  import gauge_pkg::*;
#(
  parameter int RESUME_COUNT = 8
) (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic HEAVY_DISCHARGE_I,
  input wire logic RESET_CMD_I,
  input wire logic CHARGE_EVENT_I,
  input wire logic [MV_W-1:0] CELL_MV_O,
  input wire logic [7:0] TEMP_CODE_O,
  input wire logic [7:0] CHARGE_COUNT_LOW_O,
  input wire logic [7:0] CHARGE_COUNT_HIGH_O,
  input wire logic [15:0] DISCHARGE_COUNT_O,
  input wire logic [15:0] LEARNED_CAPACITY_O,
  input wire logic EARLY_FLAG_O,
  input wire logic EMPTY_FLAG_O,
  input wire logic EMPTY_O,
  input wire logic EMPTY_OE_O,
  input wire logic FAULT_O,
  input wire logic BATT_PRESENT_O,
  input wire logic VALID_CHARGE_O
);
  wire [15:0] count = {CHARGE_COUNT_HIGH_O, CHARGE_COUNT_LOW_O};
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  // ----
  // properties
  // ----
  sequence heavy_held;
    HEAVY_DISCHARGE_I [*3];
  endsequence
  sequence pulse_end;
    VALID_CHARGE_O ##1 !VALID_CHARGE_O;
  endsequence
  a_empty_pin: assert property (!EMPTY_O && EMPTY_OE_O == !EMPTY_FLAG_O)
    else $error("empty pin disagrees with empty flag");
  a_flag_sticky: assert property ($fell(EARLY_FLAG_O) |-> VALID_CHARGE_O || $past(VALID_CHARGE_O))
    else $error("early flag dropped without valid charge");
  a_heavy_pause: assert property (heavy_held |=> !$rose(EARLY_FLAG_O) && !$rose(EMPTY_FLAG_O))
    else $error("flag set during heavy discharge");
  a_present_level: assert property (BATT_PRESENT_O == (CELL_MV_O > PRESENT_MV))
    else $error("battery present level wrong");
  a_fault_level: assert property (FAULT_O |-> CELL_MV_O > MAX_CELL_MV)
    else $error("fault without high cell voltage");
  a_temp_code: assert property (TEMP_CODE_O[3:0] == 4'h0 && TEMP_CODE_O[7:4] <= TEMP_CODE_MAX)
    else $error("temperature code out of range");
  a_valid_carry: assert property (VALID_CHARGE_O |->
    ($past(CHARGE_EVENT_I, 2) || $past(CHARGE_EVENT_I, 3)) ##0 pulse_end)
    else $error("valid charge without charge or too long");
  a_count_cap: assert property (count <= LEARNED_CAPACITY_O)
    else $error("available charge above capacity");
  a_reset_cmd: assert property (RESET_CMD_I |-> ##[2:5] (count == 16'h0000))
    else $error("reset command did not clear count");
  a_dcr_clear: assert property ((count == LEARNED_CAPACITY_O && count != 16'h0000) |->
    ##[0:3] (DISCHARGE_COUNT_O == 16'h0000))
    else $error("discharge count not cleared at full");
endmodule // gauge_chk

bind gas_gauge_threshold_counter gauge_chk #(.RESUME_COUNT(RESUME_COUNT)) u_chk (
  .MCLK_I(MCLK_I), .SRST_I(SRST_I), .HEAVY_DISCHARGE_I(HEAVY_DISCHARGE_I),
  .RESET_CMD_I(RESET_CMD_I), .CHARGE_EVENT_I(CHARGE_EVENT_I), .CELL_MV_O(CELL_MV_O),
  .TEMP_CODE_O(TEMP_CODE_O), .CHARGE_COUNT_LOW_O(CHARGE_COUNT_LOW_O),
  .CHARGE_COUNT_HIGH_O(CHARGE_COUNT_HIGH_O), .DISCHARGE_COUNT_O(DISCHARGE_COUNT_O),
  .LEARNED_CAPACITY_O(LEARNED_CAPACITY_O), .EARLY_FLAG_O(EARLY_FLAG_O),
  .EMPTY_FLAG_O(EMPTY_FLAG_O), .EMPTY_O(EMPTY_O), .EMPTY_OE_O(EMPTY_OE_O), .FAULT_O(FAULT_O),
  .BATT_PRESENT_O(BATT_PRESENT_O), .VALID_CHARGE_O(VALID_CHARGE_O)
);

// ---- bench/cell_network_model.sv ----
`timescale 1ns/1ps
module cell_network_model (
  input wire logic clk_i,
  input wire logic [15:0] pack_mv_i,
  input wire logic [2:0] cells_i,
  input wire logic signed [15:0] sense_mv_i,
  output logic [11:0] cell_mv_o,
  output logic heavy_o
);
  initial begin
    cell_mv_o = 12'h4B0;
    heavy_o = 1'b0;
  end
  // ----
  // divider and current comparator, settle just after the edge
  // ----
  always @(posedge clk_i) begin
    cell_mv_o <= #1 12'(pack_mv_i / 16'(cells_i));
    heavy_o <= #1 (sense_mv_i <= -16'sd250);
  end
endmodule // cell_network_model

// ---- bench/tb_gas_gauge_threshold_counter.sv ----
`timescale 1ns/1ps
module tb_gas_gauge_threshold_counter;
  import gauge_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] pack_mv = 16'h1C20;
  logic signed [15:0] sense = 16'sh0000;
  logic thr_wr = 1'b0;
  logic cmd = 1'b0;
  logic chg = 1'b0;
  logic dsg = 1'b0;
  logic fast = 1'b0;
  logic self_ev = 1'b0;
  logic signed [7:0] temp = 8'sh19;
  logic [1:0] prog1 = LVL_FLOAT;
  logic [1:0] prog2 = LVL_FLOAT;
  wire [11:0] cell_mv, cell_q;
  wire [7:0] temp_q, cnt_lo, cnt_hi;
  wire [15:0] dis_cnt, learned, full_cap;
  wire heavy, early_f, empty_f, empty_pin, empty_oe, present, valid, fault;
  wire [4:0] bars;
  int mismatches = 0;
  int tests_run = 0;
  int vc = 0;
  int v0;

  cell_network_model model (.clk_i(clk), .pack_mv_i(pack_mv), .cells_i(3'h6),
    .sense_mv_i(sense), .cell_mv_o(cell_mv), .heavy_o(heavy));
  gas_gauge_threshold_counter #(.RESUME_COUNT(8)) dut (
    .MCLK_I(clk), .SRST_I(srst), .CELL_MV_I(cell_mv), .HEAVY_DISCHARGE_I(heavy),
    .THRESH_WR_I(thr_wr), .EARLY_LEVEL_I(12'h514), .EMPTY_LEVEL_I(12'h44C),
    .RESET_CMD_I(cmd), .TEMP_C_I(temp), .FAST_RATE_I(fast), .CHARGE_EVENT_I(chg),
    .DISCHARGE_EVENT_I(dsg), .SELF_DISCHARGE_EVENT_I(self_ev), .PROG1_I(prog1),
    .PROG2_I(prog2), .PROG3_I(LVL_FLOAT), .PROG4_I(LVL_LOW), .CELL_MV_O(cell_q),
    .TEMP_CODE_O(temp_q), .CHARGE_COUNT_LOW_O(cnt_lo), .CHARGE_COUNT_HIGH_O(cnt_hi),
    .DISCHARGE_COUNT_O(dis_cnt), .LEARNED_CAPACITY_O(learned),
    .PROGRAMMED_FULL_CAPACITY_O(full_cap), .EARLY_FLAG_O(early_f), .EMPTY_FLAG_O(empty_f),
    .EMPTY_O(empty_pin), .EMPTY_OE_O(empty_oe), .FAULT_O(fault), .BATT_PRESENT_O(present),
    .VALID_CHARGE_O(valid), .DISPLAY_BARS_O(bars));

  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (valid === 1'b1) begin
      vc <= vc + 1;
    end
  end
  // ----
  // helpers
  // ----
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic set_cell(input int mv);
    pack_mv = 16'(mv * 6);
  endtask
  // events held high for n edges back to back, counts settle one edge later
  task automatic ev(input logic up, input int n);
    chg = up;
    dsg = !up;
    step(n);
    chg = 1'b0;
    dsg = 1'b0;
    step(3);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_init;
    chk(full_cap, 16'h8400);
    chk(learned, 16'h8400);
    chk({cnt_hi, cnt_lo}, 16'h0000);
    chk({empty_pin, empty_oe}, 16'h0001);
  endtask
  task automatic t_temp;
    int t [8] = '{-31, -30, -1, 0, 79, 81, 100, 25};
    int e;
    foreach (t[i]) begin
      temp = 8'(t[i]);
      step(3);
      e = (t[i] < -30) ? 0 : (t[i] + 40) / 10;
      e = (e > 12) ? 12 : e;
      chk(temp_q, 16'({e[3:0], 4'h0}));
    end
  endtask
  task automatic t_count;
    ev(1'b1, 10);
    chk({cnt_hi, cnt_lo}, 16'h0028);
    ev(1'b0, 2);
    chk({cnt_lo, dis_cnt[7:0]}, 16'h2008);
    ev(1'b1, 1);
    chk(cnt_lo, 8'h04);
    ev(1'b0, 3);
    chk({cnt_lo, dis_cnt[7:0]}, 16'h0014);
  endtask
  // fast rate cuts charge weight to 14/16; self-discharge weight 4/16 ignores rate
  task automatic t_comp;
    fast = 1'b1;
    ev(1'b1, 8);
    chk(cnt_lo, 8'h1C);
    self_ev = 1'b1;
    step(8);
    self_ev = 1'b0;
    step(3);
    chk({cnt_lo, dis_cnt[7:0]}, 16'h141C);
    fast = 1'b0;
  endtask
  task automatic t_valid;
    ev(1'b1, 63);
    chk({cnt_hi, cnt_lo}, 16'h00FC);
    chk(16'(vc), 16'h0000);
    ev(1'b1, 1);
    chk({cnt_hi, cnt_lo}, 16'h0100);
    chk(16'(vc), 16'h0001);
  endtask
  task automatic t_reset;
    prog1 = LVL_HIGH;
    prog2 = LVL_HIGH;
    cmd = 1'b1;
    step(1);
    cmd = 1'b0;
    step(10);
    chk({cnt_hi, cnt_lo}, 16'h0000);
    chk(full_cap, 16'hC000);
    chk(dis_cnt, 16'h0000);
    ev(1'b1, 5);
    set_cell(2300);
    step(4);
    chk({cell_q, 3'h0, present}, 16'h8FC1);
    chk(cnt_lo, 8'h14);
    chk(fault, 1'b1);
    set_cell(1200);
    step(10);
    chk(cnt_lo, 8'h00);
  endtask
  task automatic t_full;
    ev(1'b1, 12300);
    chk({cnt_hi, cnt_lo}, 16'hC000);
    chk(dis_cnt, 16'h0000);
    chk(bars, 16'h001F);
    ev(1'b0, 1);
    chk(dis_cnt, 16'h0004);
  endtask
  task automatic t_flags;
    set_cell(1000);
    step(4);
    chk({early_f, empty_f}, 16'h0002);
    set_cell(1200);
    step(4);
    chk(early_f, 1'b1);
    set_cell(900);
    step(4);
    chk(empty_oe, 1'b0);
    set_cell(1200);
    step(4);
    chk(empty_f, 1'b1);
    v0 = vc;
    ev(1'b1, 64);
    chk({cnt_hi, cnt_lo}, 16'h0000);
    chk(learned, 16'h0004);
    chk({early_f, empty_f, empty_oe}, 16'h0001);
    chk(16'(vc - v0), 16'h0001);
  endtask
  task automatic t_heavy;
    sense = -16'sd300;
    step(3);
    thr_wr = 1'b1;
    step(1);
    thr_wr = 1'b0;
    step(20);
    chk(early_f, 1'b0);
    sense = 16'sh0000;
    step(4);
    chk(early_f, 1'b0);
    step(12);
    chk({early_f, empty_f}, 16'h0002);
    set_cell(100);
    step(4);
    chk(present, 1'b0);
  endtask

  initial begin
    #300us;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    step(4);
    srst = 1'b0;
    step(10);
    t_init();
    t_temp();
    t_count();
    t_comp();
    t_valid();
    t_reset();
    t_full();
    t_flags();
    t_heavy();
    stop_test();
  end
endmodule // tb_gas_gauge_threshold_counter
